// ===== core/sled_pkg.sv
/*
 * sled_pkg: constants, register map and carrier types for the
 * front-panel status lamp controller.
 * assumes a single 10 MHz clock and a plain strobe register port.
 */
package sled_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ       = 10_000_000;
    localparam int BOOT_RED_MS  = 1000;
    localparam int BOOT_RED_CYC = (CLK_HZ / 1000) * BOOT_RED_MS;
    localparam int ACT_HOLD_US  = 100;
    localparam int ACT_HOLD_CYC = (CLK_HZ / 1_000_000) * ACT_HOLD_US;

    // ************************************************************
    // register port
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int CNT_W  = 24;

    localparam logic [ADDR_W-1:0] REG_CTRL  = 4'h0;
    localparam logic [ADDR_W-1:0] REG_PHASE = 4'h1;
    localparam logic [ADDR_W-1:0] REG_CODE  = 4'h2;
    localparam logic [ADDR_W-1:0] REG_STAT  = 4'h3;
    localparam logic [ADDR_W-1:0] REG_MASK  = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATE = 4'h5;

    localparam int CTRL_CLR_ERR = 0;
    localparam int CTRL_HOLD    = 1;
    localparam int ST_ERR_BIT   = 0;
    localparam int ST_BOOT_BIT  = 1;
    localparam int STATE_BLK    = 8;
    localparam int CODE_W       = 5;
    localparam int EV_W         = 2;

    localparam logic [DATA_W-1:0] PHASE_RST = 16'h0400;
    localparam logic [EV_W-1:0]   MASK_RST  = 2'h0;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef struct packed {
        logic red;
        logic green;
    } sled_lamp_s;

    typedef struct packed {
        sled_lamp_s rts;
        sled_lamp_s cts;
        sled_lamp_s td;
        sled_lamp_s rd;
        sled_lamp_s cd;
    } sled_panel_s;

    typedef struct packed {
        logic tx_on;
        logic noise;
        logic rx_valid;
    } sled_radio_s;

    localparam sled_lamp_s LAMP_OFF    = 2'h0;
    localparam sled_lamp_s LAMP_GREEN  = 2'h1;
    localparam sled_lamp_s LAMP_RED    = 2'h2;
    localparam sled_lamp_s LAMP_ORANGE = 2'h3;

    typedef enum logic [4:0] {
        ST_NORM = 5'b00001,
        ST_BOOT = 5'b00010,
        ST_ON   = 5'b00100,
        ST_OFF  = 5'b01000,
        ST_CODE = 5'b10000
    } sled_state_e;

endpackage : sled_pkg

// ===== core/sled_sync.sv
/*
 * sled_sync: two-flop synchroniser for asynchronous pin levels.
 * assumes the inputs are slow levels; no pulse is guaranteed to pass.
 */
`timescale 1ns/1ns
module sled_sync #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_r <= '0;
            q_r    <= '0;
        end else begin
            meta_r <= d;
            q_r    <= meta_r;
        end
    end

    assign q = q_r;

endmodule : sled_sync

// ===== core/sled_activity.sv
/*
 * sled_activity: per-lane line activity detector; any edge on a lane
 * holds its active flag for HOLD cycles so short bursts stay visible.
 * assumes inputs are already in the mclk domain.
 */
`timescale 1ns/1ns
module sled_activity #(
    parameter int W    = 2,
    parameter int HOLD = 1000
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // lines
    input  wire logic [W-1:0] line,
    output logic      [W-1:0] act
);

    localparam logic [15:0] HOLD_V = 16'(HOLD);

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_lane
            logic        prev_r;
            logic [15:0] cnt_r;
            wire         edge_w = line[g] ^ prev_r;

            always_ff @(posedge mclk) begin
                if (rst) begin
                    prev_r <= 1'b0;
                    cnt_r  <= 16'h0000;
                end else begin
                    prev_r <= line[g];
                    cnt_r  <= edge_w ? HOLD_V : (cnt_r != 16'h0000 ? cnt_r - 16'h0001 : cnt_r);
                end
            end

            assign act[g] = (cnt_r != 16'h0000);
        end
    endgenerate

endmodule : sled_activity

// ===== core/sled_ctrl.sv
/*
 * sled_ctrl: front-panel status lamp controller of a radio modem.
 * five lamps, td and radio two-colour, show the data port handshake and data lines
 * and the radio state; self-diagnostic faults put the block into an
 * error state that blocks data and cycles the lamps.
 * assumes rts/td are host pins (synchronised here); cts, rd, radio
 * state, test tx and diagnostics come from logic on mclk.
 */
`timescale 1ns/1ns

// Overview of operation
// - five lamps for data port and radio, each off or a colour
// - rts lamp dark when host rts inactive, red when active
// - cts lamp dark when cts to host inactive, red when active
// - td lamp dark idle, red on host data, green during test tx
// - rd lamp dark idle, red while sending data to the host
// - radio lamp: dark, red transmitting, orange noise, green reception
// - radio lamp independent of carrier-detect pin; they may differ
// - startup fault: all lamps red for one second, then error code
// - diagnostic error enters error state blocking data both ways
// - error state cycles all on, all off, error code, repeat
module sled_ctrl #(
    parameter int BOOT_CYC = sled_pkg::BOOT_RED_CYC
) (
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst,
    // register port
    input  wire logic [sled_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [sled_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [sled_pkg::DATA_W-1:0] reg_rdata,
    // data port lines
    input  wire logic                        rts_pin,
    input  wire logic                        td_pin,
    input  wire logic                        cts_line,
    input  wire logic                        rd_line,
    input  wire logic                        test_tx,
    // radio state
    input  wire sled_pkg::sled_radio_s       radio,
    // self-diagnostics
    input  wire logic                        diag_fault,
    input  wire logic                        diag_startup,
    input  wire logic [sled_pkg::CODE_W-1:0] diag_code,
    // outputs
    output sled_pkg::sled_panel_s            panel,
    output logic                             data_block,
    output logic                             irq
);

    localparam logic [sled_pkg::CNT_W-1:0] BOOT_LIM = sled_pkg::CNT_W'(BOOT_CYC - 1);

    // ************************************************************
    // pin synchronisation and activity
    // ************************************************************
    logic [1:0] pins_s;
    logic [1:0] act;

    sled_sync #(.W(2)) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .d    ({td_pin, rts_pin}),
        .q    (pins_s)
    );

    sled_activity #(.W(2), .HOLD(sled_pkg::ACT_HOLD_CYC)) u_act (
        .mclk (mclk),
        .rst  (rst),
        .line ({rd_line, pins_s[1]}),
        .act  (act)
    );

    wire rts_s  = pins_s[0];
    wire td_act = act[0];
    wire rd_act = act[1];

    // ************************************************************
    // registers
    // ************************************************************
    logic [sled_pkg::DATA_W-1:0] phase_r;
    logic [sled_pkg::CODE_W-1:0] code_r;
    logic [sled_pkg::EV_W-1:0]   stat_r;
    logic [sled_pkg::EV_W-1:0]   mask_r;
    logic                        hold_r;
    logic [sled_pkg::DATA_W-1:0] rdata_r;

    sled_pkg::sled_state_e       state_r;
    sled_pkg::sled_state_e       state_nxt;
    logic [sled_pkg::CNT_W-1:0]  cnt_r;

    wire wr_ctrl  = reg_wr && (reg_addr == sled_pkg::REG_CTRL);
    wire wr_phase = reg_wr && (reg_addr == sled_pkg::REG_PHASE);
    wire wr_stat  = reg_wr && (reg_addr == sled_pkg::REG_STAT);
    wire wr_mask  = reg_wr && (reg_addr == sled_pkg::REG_MASK);
    wire clr_err  = wr_ctrl && reg_wdata[sled_pkg::CTRL_CLR_ERR];

    // ************************************************************
    // error state machine
    // ************************************************************
    wire in_norm   = (state_r == sled_pkg::ST_NORM);
    wire fault_acc = in_norm && diag_fault;
    // zero phase length would stall the cycle; treat it as one cycle
    wire [sled_pkg::DATA_W-1:0] phase_lim = (phase_r == '0) ? '0 : phase_r - 16'h0001;
    wire [sled_pkg::CNT_W-1:0] lim_w =
        (state_r == sled_pkg::ST_BOOT) ? BOOT_LIM : sled_pkg::CNT_W'(phase_lim);
    // hold freezes the cycle on its current phase for inspection
    wire phase_end = (cnt_r >= lim_w) && !hold_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            sled_pkg::ST_NORM: begin
                if (fault_acc) begin
                    state_nxt = diag_startup ? sled_pkg::ST_BOOT : sled_pkg::ST_ON;
                end
            end
            sled_pkg::ST_BOOT: begin
                if (cnt_r >= BOOT_LIM) begin
                    state_nxt = sled_pkg::ST_CODE;
                end
            end
            sled_pkg::ST_ON: begin
                if (phase_end) begin
                    state_nxt = sled_pkg::ST_OFF;
                end
            end
            sled_pkg::ST_OFF: begin
                if (phase_end) begin
                    state_nxt = sled_pkg::ST_CODE;
                end
            end
            sled_pkg::ST_CODE: begin
                if (phase_end) begin
                    state_nxt = sled_pkg::ST_ON;
                end
            end
        endcase
        if (!in_norm && clr_err) begin
            state_nxt = sled_pkg::ST_NORM;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= sled_pkg::ST_NORM;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= (state_nxt != state_r) ? '0 : cnt_r + 24'h000001;
        end
    end

    // ************************************************************
    // register writes and sticky events
    // ************************************************************
    wire [sled_pkg::EV_W-1:0] ev_w = {fault_acc && diag_startup, fault_acc};
    wire [sled_pkg::EV_W-1:0] st_clr = wr_stat ? reg_wdata[sled_pkg::EV_W-1:0] : '0;

    always_ff @(posedge mclk) begin
        if (rst) begin
            phase_r <= sled_pkg::PHASE_RST;
            code_r  <= '0;
            stat_r  <= '0;
            mask_r  <= sled_pkg::MASK_RST;
            hold_r  <= 1'b0;
        end else begin
            if (wr_phase) begin
                phase_r <= reg_wdata;
            end
            if (fault_acc) begin
                code_r <= diag_code;
            end
            if (wr_mask) begin
                mask_r <= reg_wdata[sled_pkg::EV_W-1:0];
            end
            if (wr_ctrl) begin
                hold_r <= reg_wdata[sled_pkg::CTRL_HOLD];
            end
            // a new event wins over a clear in the same cycle
            stat_r <= (stat_r & ~st_clr) | ev_w;
        end
    end

    // ************************************************************
    // register reads
    // ************************************************************
    logic [sled_pkg::DATA_W-1:0] rmux;

    always_comb begin
        rmux = '0;
        unique case (reg_addr)
            sled_pkg::REG_CTRL:  rmux[sled_pkg::CTRL_HOLD] = hold_r;
            sled_pkg::REG_PHASE: rmux = phase_r;
            sled_pkg::REG_CODE:  rmux[sled_pkg::CODE_W-1:0] = code_r;
            sled_pkg::REG_STAT:  rmux[sled_pkg::EV_W-1:0] = stat_r;
            sled_pkg::REG_MASK:  rmux[sled_pkg::EV_W-1:0] = mask_r;
            sled_pkg::REG_STATE: begin
                rmux[4:0] = state_r;
                rmux[sled_pkg::STATE_BLK] = !in_norm;
            end
            default:             rmux = '0;
        endcase
    end

    // ************************************************************
    // lamp selection
    // ************************************************************
    sled_pkg::sled_panel_s norm_w;
    sled_pkg::sled_panel_s err_w;
    sled_pkg::sled_panel_s panel_nxt;

    assign norm_w.rts = rts_s    ? sled_pkg::LAMP_RED : sled_pkg::LAMP_OFF;
    assign norm_w.cts = cts_line ? sled_pkg::LAMP_RED : sled_pkg::LAMP_OFF;
    // test transmission outranks host data on the td lamp
    assign norm_w.td  = test_tx ? sled_pkg::LAMP_GREEN :
                        td_act  ? sled_pkg::LAMP_RED : sled_pkg::LAMP_OFF;
    assign norm_w.rd  = rd_act  ? sled_pkg::LAMP_RED : sled_pkg::LAMP_OFF;
    // radio lamp is taken from radio state only, never from the cd pin
    assign norm_w.cd  = radio.tx_on    ? sled_pkg::LAMP_RED :
                        radio.rx_valid ? sled_pkg::LAMP_GREEN :
                        radio.noise    ? sled_pkg::LAMP_ORANGE :
                                         sled_pkg::LAMP_OFF;

    wire [4:0] code_red = (state_r == sled_pkg::ST_CODE) ? code_r :
                          (state_r == sled_pkg::ST_OFF)  ? 5'h00 : 5'h1f;
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_err
            assign err_w[2*g+1] = code_red[g];
            assign err_w[2*g]   = 1'b0;
        end
    endgenerate

    assign panel_nxt = in_norm ? norm_w : err_w;

    // ************************************************************
    // output flops
    // ************************************************************
    sled_pkg::sled_panel_s panel_r;
    logic                  block_r;
    logic                  irq_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            panel_r <= '0;
            block_r <= 1'b0;
            irq_r   <= 1'b0;
            rdata_r <= '0;
        end else begin
            panel_r <= panel_nxt;
            block_r <= (state_nxt != sled_pkg::ST_NORM);
            irq_r   <= |(((stat_r & ~st_clr) | ev_w) & mask_r);
            rdata_r <= reg_rd ? rmux : '0;
        end
    end

    assign panel      = panel_r;
    assign data_block = block_r;
    assign irq        = irq_r;
    assign reg_rdata  = rdata_r;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic [sled_pkg::CNT_W-1:0] boot_len_r;
    always_ff @(posedge mclk) begin
        if (rst) begin
            boot_len_r <= '0;
        end else begin
            boot_len_r <= (state_r == sled_pkg::ST_BOOT) ? boot_len_r + 24'h000001 : '0;
        end
    end

    a_rts_lamp_red: assert property (
        in_norm && rts_s |=> panel.rts == sled_pkg::LAMP_RED)
        else $error("rts lamp not red");
    a_cts_lamp_off: assert property (
        in_norm && !cts_line |=> panel.cts == sled_pkg::LAMP_OFF)
        else $error("cts lamp not dark");
    a_td_test_green: assert property (
        in_norm && test_tx |=> panel.td == sled_pkg::LAMP_GREEN)
        else $error("td lamp not green in test");
    a_rd_idle_dark: assert property (
        in_norm && !rd_act |=> panel.rd == sled_pkg::LAMP_OFF)
        else $error("rd lamp lit without data");
    a_cd_noise_orange: assert property (
        in_norm && radio.noise && !radio.tx_on && !radio.rx_valid
        |=> panel.cd == sled_pkg::LAMP_ORANGE)
        else $error("radio lamp not orange on noise");
    a_boot_all_red: assert property (
        state_r == sled_pkg::ST_BOOT |=> panel == 10'h2aa)
        else $error("startup fault lamps not all red");
    a_boot_len_exact: assert property (
        $fell(state_r == sled_pkg::ST_BOOT) && !$past(clr_err)
        |-> $past(boot_len_r) == BOOT_LIM && state_r == sled_pkg::ST_CODE)
        else $error("startup red phase wrong length");
    a_err_blocks: assert property (
        !in_norm |-> data_block)
        else $error("data not blocked in error state");
    a_off_after_on: assert property (
        $changed(state_r) && state_r == sled_pkg::ST_OFF
        |-> $past(state_r) == sled_pkg::ST_ON)
        else $error("error cycle order broken");
    a_code_shown: assert property (
        state_r == sled_pkg::ST_CODE |=> panel[9:0] == {
            code_r[4], 1'b0, code_r[3], 1'b0, code_r[2], 1'b0,
            code_r[1], 1'b0, code_r[0], 1'b0})
        else $error("error code pattern wrong");
    a_code_held: assert property (
        !in_norm && !$past(in_norm) |-> $stable(code_r))
        else $error("error code changed in error state");
    a_phase_len: assert property (
        state_r == sled_pkg::ST_CODE && $past(state_r) == sled_pkg::ST_OFF
        && $past(phase_r) == 16'h0004 |-> $past(cnt_r) == 24'h000003)
        else $error("phase length not honoured");
    a_err_override: assert property (
        state_r == sled_pkg::ST_OFF |=> panel == '0)
        else $error("normal lamps shown in error state");

    c_boot_seq: cover property (
        state_r == sled_pkg::ST_BOOT ##1 state_r == sled_pkg::ST_BOOT [*2]);
    c_full_cycle: cover property (
        state_r == sled_pkg::ST_CODE ##1 state_r == sled_pkg::ST_ON);
    c_clear_exit: cover property (!in_norm ##1 in_norm);
    c_test_tx: cover property (in_norm && test_tx && td_act);

endmodule : sled_ctrl

// ===== testbench/sled_panel_model.sv
/*
 * sled_panel_model: behavioural bank of five front-panel lamps, only td and radio two-colour.
 * assumes the panel bus drives the lamps directly; reports how many lamps
 * are lit and whether a lamp shows a colour that it does not have.
 */
`timescale 1ns/1ns
module sled_panel_model (
    // lamp drive
    input  wire sled_pkg::sled_panel_s panel,
    // observation
    output logic [2:0]                 lit,
    output logic                       bad_colour
);
    // ************************************************************
    // lamp bank
    // ************************************************************
    // a lamp with only a red die cannot glow green; green there means a wiring fault
    always_comb begin
        lit        = 3'h0;
        bad_colour = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (panel[2*i +: 2] != 2'h0) begin
                lit = lit + 3'h1;
            end
            if ((i == 1 || i == 3 || i == 4) && panel[2*i]) begin
                bad_colour = 1'b1;
            end
        end
    end
endmodule : sled_panel_model

// ===== testbench/sled_ctrl_test.sv
/*
 * sled_ctrl_test: self-checking bench for the status lamp controller.
 * assumes sled_pkg is compiled first; short boot and phase counts keep the run brief.
 */
`timescale 1ns/1ns
module sled_ctrl_test;
    // ************************************************************
    // signals
    // ************************************************************
    localparam int BOOT = 20;
    localparam int PH   = 4;
    localparam sled_pkg::sled_panel_s ALL_RED = 10'h2aa;
    logic                        mclk, rst, reg_wr, reg_rd, rts_pin, td_pin, cts_line;
    logic                        rd_line, test_tx, diag_fault, diag_startup, data_block, irq;
    logic [sled_pkg::ADDR_W-1:0] reg_addr;
    logic [sled_pkg::DATA_W-1:0] reg_wdata, reg_rdata;
    logic [sled_pkg::CODE_W-1:0] diag_code;
    sled_pkg::sled_radio_s       radio;
    sled_pkg::sled_panel_s       panel;
    logic [2:0]                  lit;
    logic                        bad_colour;
    int                          err_count, comparisons, n;
    integer                      seed;
    logic [15:0]                 v;

    sled_ctrl #(.BOOT_CYC(BOOT)) sled_ctrl_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rts_pin(rts_pin), .td_pin(td_pin), .cts_line(cts_line), .rd_line(rd_line),
        .test_tx(test_tx), .radio(radio), .diag_fault(diag_fault),
        .diag_startup(diag_startup), .diag_code(diag_code), .panel(panel),
        .data_block(data_block), .irq(irq));
    sled_panel_model sled_panel_model_i (.panel(panel), .lit(lit), .bad_colour(bad_colour));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // ************************************************************
    // expectations and checks
    // ************************************************************
    function automatic sled_pkg::sled_panel_s exp_norm(logic r, logic c, logic t,
                                                       sled_pkg::sled_radio_s rs);
        sled_pkg::sled_panel_s p;
        p     = '0;
        p.rts = r ? sled_pkg::LAMP_RED : sled_pkg::LAMP_OFF;
        p.cts = c ? sled_pkg::LAMP_RED : sled_pkg::LAMP_OFF;
        p.td  = t ? sled_pkg::LAMP_GREEN : sled_pkg::LAMP_OFF;
        p.cd  = rs.tx_on ? sled_pkg::LAMP_RED : rs.rx_valid ? sled_pkg::LAMP_GREEN :
                rs.noise ? sled_pkg::LAMP_ORANGE : sled_pkg::LAMP_OFF;
        return p;
    endfunction : exp_norm

    // code bit 4 lands on the rts lamp, bit 0 on the radio lamp
    function automatic sled_pkg::sled_panel_s exp_code(logic [4:0] c);
        sled_pkg::sled_panel_s p;
        p = '0;
        for (int i = 0; i < 5; i++) p[2*i+1] = c[i];
        return p;
    endfunction : exp_code

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk16

    task automatic chk_pnl(input sled_pkg::sled_panel_s got, input sled_pkg::sled_panel_s exp,
                           input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s lamps %h exp %h", $time, what, got, exp);
        end
    endtask : chk_pnl

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask : rd

    task automatic fault(input logic st, input logic [4:0] c);
        @(posedge mclk);
        diag_fault   <= 1'b1;
        diag_startup <= st;
        diag_code    <= c;
        @(posedge mclk);
        diag_fault <= 1'b0;
    endtask : fault

    task automatic wait_pnl(input sled_pkg::sled_panel_s e);
        n = 0;
        while (panel !== e && n < 3000) begin
            n++;
            @(negedge mclk);
        end
        chk16(16'(panel), 16'(e), "lamp pattern never shown");
    endtask : wait_pnl

    task automatic run_len(input sled_pkg::sled_panel_s e, input int exp, input string what);
        n = 0;
        while (panel === e && n < 3000) begin
            n++;
            @(negedge mclk);
        end
        chk16(16'(n), 16'(exp), what);
    endtask : run_len

    task automatic results;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    // a hang costs a mismatch; the tests need about 5000 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        seed = 32'h30f7;
        rst = 1'b1;
        {reg_wr, reg_rd, rts_pin, td_pin, cts_line, rd_line, test_tx} = 7'h0;
        {diag_fault, diag_startup, diag_code, reg_addr, reg_wdata} = '0;
        radio = '0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk_pnl(panel, '0, "reset lamps");
        chk16({14'h0, data_block, irq}, 16'h0, "reset flags");
        rd(sled_pkg::REG_PHASE, v); chk16(v, sled_pkg::PHASE_RST, "phase reset");
        rd(sled_pkg::REG_MASK, v); chk16(v, 16'(sled_pkg::MASK_RST), "mask reset");
        rd(sled_pkg::REG_STAT, v); chk16(v, 16'h0, "status reset");
        rd(sled_pkg::REG_CODE, v); chk16(v, 16'h0, "code reset");
        wr(4'he, 16'hffff);
        rd(4'he, v); chk16(v, 16'h0, "unmapped read");
        $display("test reset done");
        for (int k = 0; k < 40; k++) begin
            @(posedge mclk);
            rts_pin  <= 1'($random(seed));
            cts_line <= 1'($random(seed));
            test_tx  <= 1'($random(seed));
            radio    <= 3'($random(seed));
            repeat (5) @(posedge mclk);
            @(negedge mclk);
            chk_pnl(panel, exp_norm(rts_pin, cts_line, test_tx, radio), "line lamps");
            chk16(16'(bad_colour), 16'h0, "lamp colour");
        end
        $display("test line lamps done");
        @(posedge mclk);
        td_pin  <= ~td_pin;
        rd_line <= ~rd_line;
        test_tx <= 1'b0;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        chk16(16'(panel.td), 16'(sled_pkg::LAMP_RED), "td data");
        chk16(16'(panel.rd), 16'(sled_pkg::LAMP_RED), "rd data");
        @(posedge mclk);
        test_tx <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk16(16'(panel.td), 16'(sled_pkg::LAMP_GREEN), "td test tx");
        @(posedge mclk);
        test_tx <= 1'b0;
        repeat (880) @(posedge mclk);
        @(negedge mclk);
        chk16(16'(panel.rd), 16'(sled_pkg::LAMP_RED), "rd still lit");
        repeat (120) @(posedge mclk);
        @(negedge mclk);
        chk16(16'({panel.td, panel.rd}), 16'h0, "activity expired");
        $display("test activity done");
        wr(sled_pkg::REG_PHASE, 16'(PH));
        wr(sled_pkg::REG_MASK, 16'h1);
        @(posedge mclk);
        {rts_pin, cts_line, radio} <= 5'b11100;
        fault(1'b0, 5'h15);
        wait_pnl(ALL_RED);
        chk16(16'(lit), 16'h5, "five lamps lit");
        chk16(16'(data_block), 16'h1, "data blocked");
        run_len(ALL_RED, PH, "all on phase");
        run_len('0, PH, "all off phase");
        run_len(exp_code(5'h15), PH, "code phase");
        run_len(ALL_RED, PH, "all on again");
        fault(1'b0, 5'h03);
        rd(sled_pkg::REG_CODE, v); chk16(v, 16'h0015, "code held");
        rd(sled_pkg::REG_STATE, v); chk16(16'(v[sled_pkg::STATE_BLK]), 16'h1, "state blocked");
        rd(sled_pkg::REG_STAT, v); chk16(v, 16'h0001, "error event");
        chk16(16'(irq), 16'h1, "irq raised");
        wr(sled_pkg::REG_STAT, 16'h1);
        rd(sled_pkg::REG_STAT, v); chk16(v, 16'h0, "event cleared");
        chk16(16'(irq), 16'h0, "irq cleared");
        wr(sled_pkg::REG_CTRL, 16'h2);
        rd(sled_pkg::REG_CTRL, v); chk16(v, 16'h2, "hold readback");
        run_len(panel, 3000, "phase frozen by hold");
        wr(sled_pkg::REG_CTRL, 16'h1);
        repeat (4) @(negedge mclk);
        chk16(16'(data_block), 16'h0, "data unblocked");
        chk_pnl(panel, exp_norm(1'b1, 1'b1, 1'b0, 3'b100), "lamps restored");
        $display("test error state done");
        wr(sled_pkg::REG_MASK, 16'h0);
        fault(1'b1, 5'h0a);
        wait_pnl(ALL_RED);
        run_len(ALL_RED, BOOT, "start-up red");
        run_len(exp_code(5'h0a), PH, "start-up code");
        run_len(ALL_RED, PH, "start-up cycle");
        rd(sled_pkg::REG_STAT, v); chk16(v, 16'h0003, "start-up events");
        chk16(16'(irq), 16'h0, "irq masked");
        wr(sled_pkg::REG_MASK, 16'h2);
        rd(sled_pkg::REG_MASK, v); chk16(v, 16'h0002, "mask readback");
        chk16(16'(irq), 16'h1, "irq unmasked");
        wr(sled_pkg::REG_STAT, 16'h3);
        wr(sled_pkg::REG_CTRL, 16'h1);
        repeat (4) @(negedge mclk);
        chk16({14'h0, data_block, irq}, 16'h0, "start-up left");
        $display("test start-up fault done");
        results();
    end
endmodule : sled_ctrl_test
